// *** include/mbc_pkg.sv ***
// ============================================================
// memory self-test control: shared constants and types
package mbc_pkg;

    // ============================================================
    // microprocessor port
    localparam int unsigned CPU_AW              = 14;
    localparam int unsigned CPU_DW              = 16;
    localparam logic [13:0] SELF_TEST_REG_ADDR  = 14'h014d;
    localparam logic [15:0] SELF_TEST_REG_RESET = 16'h0000;

    // ============================================================
    // field layout of the self-test register
    localparam int unsigned SELF_TEST_ENABLE_BIT = 12;
    localparam int unsigned PASS_BIT_BASE        = 0;   // local conn memory pass
    localparam int unsigned DONE_BIT_BASE        = 1;   // local conn memory done
    localparam int unsigned START_BIT_BASE       = 2;   // local conn memory start
    localparam int unsigned FIELD_STRIDE         = 3;   // next memory: 3 bits higher

    // ============================================================
    // memories under test: 0 local conn, 1 bp conn, 2 local data, 3 bp data
    localparam int unsigned MEM_CNT       = 4;
    localparam int unsigned MEM_DW        = 16;
    localparam int unsigned MEM_AW_MAX    = 12;
    localparam logic [15:0] PATTERN_FIRST  = 16'h5555;
    localparam logic [15:0] PATTERN_SECOND = 16'haaaa;

    // ============================================================
    // test engine states, one-hot
    typedef enum logic [4:0] {
        mbc_st_idle   = 5'h01,
        mbc_st_write  = 5'h02,
        mbc_st_read   = 5'h04,
        mbc_st_settle = 5'h08,
        mbc_st_done   = 5'h10
    } mbc_state_t;

endpackage

// *** include/mbc_seq_if.sv ***
`timescale 1ns/100ps
// ============================================================
// control and status between register file and one test engine
interface mbc_seq_if;
    logic start;   // one-cycle pulse, restarts the sequence
    logic clear;   // level, test mode is off
    logic done;
    logic pass;

    modport ctl (output start, output clear, input done, input pass);
    modport eng (input start, input clear, output done, output pass);
endinterface

// *** verilog/mbc_march.sv ***
`timescale 1ns/100ps
// ============================================================
// two-pass write/verify engine for one memory
module mbc_march
    import mbc_pkg::*;
#(
    parameter int unsigned AW = 12
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    mbc_seq_if.eng                 seq,
    output logic [AW-1:0]          mem_addr_o,
    output logic [MEM_DW-1:0]      mem_wdata_o,
    output logic                   mem_we_o,
    input  wire logic [MEM_DW-1:0] mem_rdata_i
);

    mbc_state_t state;
    logic       second_pass;
    logic       chk_valid;
    logic       err;
    logic       mismatch;
    logic       last_addr;

    // read data lags the address by one edge of the memory, so compare late
    assign mismatch  = chk_valid && (mem_rdata_i != (second_pass ? PATTERN_SECOND : PATTERN_FIRST));
    assign last_addr = (mem_addr_o == {AW{1'b1}});

    // ============================================================
    // sequencer and memory port
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state       <= mbc_st_idle;
            second_pass <= 1'b0;
            chk_valid   <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= '0;
            mem_we_o    <= 1'b0;
        end else if (seq.clear) begin
            state       <= mbc_st_idle;
            second_pass <= 1'b0;
            chk_valid   <= 1'b0;
            mem_addr_o  <= '0;
            mem_we_o    <= 1'b0;
        end else if (seq.start) begin
            // restart wins over any sequence in flight
            state       <= mbc_st_write;
            second_pass <= 1'b0;
            chk_valid   <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= PATTERN_FIRST;
            mem_we_o    <= 1'b1;
        end else begin
            case (state)
                mbc_st_write: begin
                    mem_addr_o <= mem_addr_o + 1'b1;
                    if (last_addr) begin
                        mem_we_o <= 1'b0;
                        state    <= mbc_st_read;
                    end
                end
                mbc_st_read: begin
                    chk_valid  <= 1'b1;
                    mem_addr_o <= mem_addr_o + 1'b1;
                    if (last_addr) begin
                        state <= mbc_st_settle;
                    end
                end
                mbc_st_settle: begin
                    chk_valid <= 1'b0;
                    if (!second_pass) begin
                        second_pass <= 1'b1;
                        mem_wdata_o <= PATTERN_SECOND;
                        mem_we_o    <= 1'b1;
                        state       <= mbc_st_write;
                    end else begin
                        state <= mbc_st_done;
                    end
                end
                mbc_st_done: begin
                    state <= mbc_st_done;
                end
                default: begin
                    state <= mbc_st_idle;
                end
            endcase
        end
    end

    // ============================================================
    // error accumulation and result flags
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err      <= 1'b0;
            seq.done <= 1'b0;
            seq.pass <= 1'b0;
        end else if (seq.clear || seq.start) begin
            err      <= 1'b0;
            seq.done <= 1'b0;
            seq.pass <= 1'b0;
        end else begin
            if (mismatch) begin
                err <= 1'b1;
            end
            // last compare lands in the settle cycle itself
            if (state == mbc_st_settle && second_pass) begin
                seq.done <= 1'b1;
                seq.pass <= ~(err | mismatch);
            end
        end
    end

endmodule // mbc_march

// *** verilog/mbc_top.sv ***
`timescale 1ns/100ps
// How it works
// - bit 12 high selects memory self-test mode
// - bit 11 rise runs bp data test
// - bit 8 rise runs local data test
// - bit 5 rise runs bp conn test
// - bit 2 rise runs local conn test
// - pass flag high means memory passed
// - done and pass bits ignore writes
module mbc_top
    import mbc_pkg::*;
#(
    parameter int unsigned MEM_AW = MEM_AW_MAX
) (
    input  wire logic                           clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic [CPU_AW-1:0]              cpu_addr_i,
    input  wire logic [CPU_DW-1:0]              cpu_wdata_i,
    input  wire logic                           cpu_wr_i,
    input  wire logic                           cpu_rd_i,
    output logic      [CPU_DW-1:0]              cpu_rdata_o,
    output logic                                cpu_ack_o,
    output logic                                self_test_enable_o,
    output logic      [MEM_CNT-1:0][MEM_AW-1:0] mem_addr_o,
    output logic      [MEM_CNT-1:0][MEM_DW-1:0] mem_wdata_o,
    output logic      [MEM_CNT-1:0]             mem_we_o,
    input  wire logic [MEM_CNT-1:0][MEM_DW-1:0] mem_rdata_i
);

    // ============================================================
    // register state
    logic                self_test_enable;
    logic [MEM_CNT-1:0]  start_q;
    logic [MEM_CNT-1:0]  start_pulse;
    logic [MEM_CNT-1:0]  done_flags;
    logic [MEM_CNT-1:0]  pass_flags;
    logic [CPU_DW-1:0]   reg_view;
    logic                reg_hit;
    logic                wr_hit;

    mbc_seq_if seq_if [MEM_CNT] ();

    assign reg_hit = (cpu_addr_i == SELF_TEST_REG_ADDR);
    assign wr_hit  = cpu_wr_i && reg_hit;

    // ============================================================
    // test-mode enable; reserved bits are not stored
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            self_test_enable <= SELF_TEST_REG_RESET[SELF_TEST_ENABLE_BIT];
        end else if (wr_hit) begin
            self_test_enable <= cpu_wdata_i[SELF_TEST_ENABLE_BIT];
        end
    end

    // mirror to the rest of the chip; low means normal operation
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            self_test_enable_o <= 1'b0;
        end else begin
            self_test_enable_o <= self_test_enable;
        end
    end

    // ============================================================
    // per-memory start edge, engine and status
    for (genvar i = 0; i < MEM_CNT; i++) begin : g_mem
        localparam int unsigned SB = START_BIT_BASE + FIELD_STRIDE * i;
        localparam int unsigned DB = DONE_BIT_BASE + FIELD_STRIDE * i;
        localparam int unsigned PB = PASS_BIT_BASE + FIELD_STRIDE * i;

        // start bit as last written; the edge is taken from write to write
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                start_q[i] <= SELF_TEST_REG_RESET[SB];
            end else if (wr_hit) begin
                start_q[i] <= cpu_wdata_i[SB];
            end
        end

        // a rise only counts while test mode was already armed and stays so,
        // which enforces the two-write arming order
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                start_pulse[i] <= 1'b0;
            end else begin
                start_pulse[i] <= wr_hit && self_test_enable
                                  && cpu_wdata_i[SELF_TEST_ENABLE_BIT]
                                  && cpu_wdata_i[SB] && !start_q[i];
            end
        end

        assign seq_if[i].start = start_pulse[i];
        assign seq_if[i].clear = ~self_test_enable;
        assign done_flags[i]   = seq_if[i].done;
        assign pass_flags[i]   = seq_if[i].pass;

        // status bits come from the engine only, never from the write data
        always_comb begin
            reg_view[SB] = start_q[i];
            reg_view[DB] = done_flags[i];
            reg_view[PB] = pass_flags[i];
        end

        mbc_march #(
            .AW (MEM_AW)
        ) u_march (
            .clk_i       (clk_i),
            .sys_rst_i   (sys_rst_i),
            .seq         (seq_if[i]),
            .mem_addr_o  (mem_addr_o[i]),
            .mem_wdata_o (mem_wdata_o[i]),
            .mem_we_o    (mem_we_o[i]),
            .mem_rdata_i (mem_rdata_i[i])
        );
    end

    // upper bits of the view: enable, and reserved reading zero
    always_comb begin
        reg_view[CPU_DW-1:SELF_TEST_ENABLE_BIT+1] = '0;
        reg_view[SELF_TEST_ENABLE_BIT]            = self_test_enable;
    end

    // ============================================================
    // read path and acknowledge, one cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_rdata_o <= '0;
        end else if (cpu_rd_i) begin
            // other addresses belong to other blocks; answer zero here
            cpu_rdata_o <= reg_hit ? reg_view : '0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_ack_o <= 1'b0;
        end else begin
            cpu_ack_o <= cpu_rd_i | cpu_wr_i;
        end
    end

endmodule // mbc_top

// *** tb/mbc_top_monitor.sv ***
`timescale 1ns/100ps
// ============================================================
// port checker for the self-test control block
module mbc_top_monitor
    import mbc_pkg::*;
#(
    parameter int unsigned MEM_AW = MEM_AW_MAX
) (
    input wire logic                           clk_i,
    input wire logic                           sys_rst_i,
    input wire logic [CPU_AW-1:0]              cpu_addr_i,
    input wire logic [CPU_DW-1:0]              cpu_wdata_i,
    input wire logic                           cpu_wr_i,
    input wire logic                           cpu_rd_i,
    input wire logic [CPU_DW-1:0]              cpu_rdata_o,
    input wire logic                           cpu_ack_o,
    input wire logic                           self_test_enable_o,
    input wire logic [MEM_CNT-1:0][MEM_AW-1:0] mem_addr_o,
    input wire logic [MEM_CNT-1:0][MEM_DW-1:0] mem_wdata_o,
    input wire logic [MEM_CNT-1:0]             mem_we_o,
    input wire logic [MEM_CNT-1:0][MEM_DW-1:0] mem_rdata_i
);
    logic        hit;
    logic [15:0] shadow;
    logic        rd_reg;
    assign hit = cpu_addr_i == SELF_TEST_REG_ADDR;

    // last value written, so a start rise can be told from a rewrite
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shadow <= 16'h0000;
            rd_reg <= 1'b0;
        end else begin
            rd_reg <= cpu_rd_i && hit;
            if (cpu_wr_i && hit) begin
                shadow <= cpu_wdata_i;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ============================================================
    // access path and mode bit
    property p_ack; (cpu_wr_i || cpu_rd_i) |=> cpu_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after strobe");
    property p_hold; !$past(cpu_rd_i) |-> $stable(cpu_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_enable; cpu_wr_i && hit |-> ##2 self_test_enable_o == $past(cpu_wdata_i[12], 2); endproperty
    a_enable: assert property (p_enable) else $error("enable not following bit 12");
    property p_idle; !self_test_enable_o [*3] |-> mem_we_o == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("memory written outside test mode");
    property p_same; cpu_wr_i && hit && !shadow[12] |-> ##1 mem_we_o == 4'h0 ##1 mem_we_o == 4'h0 ##1 mem_we_o == 4'h0; endproperty
    a_same: assert property (p_same) else $error("start taken in arming write");

    // ============================================================
    // sequences and status
    property p_bp_data; cpu_wr_i && hit && shadow[12] && cpu_wdata_i[12] && cpu_wdata_i[11] && !shadow[11]
        |-> ##[1:3] mem_we_o[3] && mem_addr_o[3] == '0 && mem_wdata_o[3] == PATTERN_FIRST; endproperty
    a_bp_data: assert property (p_bp_data) else $error("bp data sequence not started");
    property p_loc_conn; cpu_wr_i && hit && shadow[12] && cpu_wdata_i[12] && cpu_wdata_i[2] && !shadow[2]
        |-> ##[1:3] mem_we_o[0] && mem_addr_o[0] == '0 && mem_wdata_o[0] == PATTERN_FIRST; endproperty
    a_loc_conn: assert property (p_loc_conn) else $error("local conn sequence not started");
    property p_loc_data; cpu_wr_i && hit && shadow[12] && cpu_wdata_i[12] && cpu_wdata_i[8] && !shadow[8]
        |-> ##[1:3] mem_we_o[2] && mem_addr_o[2] == '0 && mem_wdata_o[2] == PATTERN_FIRST; endproperty
    a_loc_data: assert property (p_loc_data) else $error("local data sequence not started");
    property p_bp_conn; cpu_wr_i && hit && shadow[12] && cpu_wdata_i[12] && cpu_wdata_i[5] && !shadow[5]
        |-> ##[1:3] mem_we_o[1] && mem_addr_o[1] == '0 && mem_wdata_o[1] == PATTERN_FIRST; endproperty
    a_bp_conn: assert property (p_bp_conn) else $error("bp conn sequence not started");
    property p_pass; cpu_ack_o && rd_reg |-> (cpu_rdata_o & ~(cpu_rdata_o >> 1) & 16'h0249) == 16'h0000; endproperty
    a_pass: assert property (p_pass) else $error("pass shown before done");
    property p_clear; cpu_ack_o && rd_reg && !self_test_enable_o && !$past(self_test_enable_o, 2)
        |-> (cpu_rdata_o & 16'h07ff & ~16'h0924) == 16'h0000; endproperty
    a_clear: assert property (p_clear) else $error("status kept outside test mode");
    property p_rsvd; cpu_ack_o && rd_reg |-> cpu_rdata_o[15:13] == 3'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
endmodule // mbc_top_monitor

bind mbc_top mbc_top_monitor #(.MEM_AW(MEM_AW)) u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_rdata_o(cpu_rdata_o), .cpu_ack_o(cpu_ack_o), .self_test_enable_o(self_test_enable_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_rdata_i(mem_rdata_i));

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the self-test control block
module tb_top;
    import mbc_pkg::*;
    localparam int unsigned AW = 3;   // short memories keep each run to a few dozen cycles
    localparam logic [13:0] RA = SELF_TEST_REG_ADDR;
    logic                       clk_i = 1'b0;
    logic                       sys_rst_i = 1'b1;
    logic [CPU_AW-1:0]          cpu_addr_i = '0;
    logic [CPU_DW-1:0]          cpu_wdata_i = '0;
    logic                       cpu_wr_i = 1'b0;
    logic                       cpu_rd_i = 1'b0;
    logic [CPU_DW-1:0]          cpu_rdata_o;
    logic                       cpu_ack_o;
    logic                       self_test_enable_o;
    logic [MEM_CNT-1:0][AW-1:0] mem_addr_o;
    logic [MEM_CNT-1:0][15:0]   mem_wdata_o;
    logic [MEM_CNT-1:0]         mem_we_o;
    logic [MEM_CNT-1:0][15:0]   mem_rdata_i;
    logic [15:0]                mem [MEM_CNT][2**AW];
    logic [MEM_CNT-1:0]         fault = '0;
    logic [15:0]                v;
    int                         errors = 0;
    int                         n_checks = 0;
    int                         cycles = 0;

    always #5 clk_i = ~clk_i;

    mbc_top #(.MEM_AW(AW)) i_mbc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o),
        .cpu_ack_o(cpu_ack_o), .self_test_enable_o(self_test_enable_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_rdata_i(mem_rdata_i));

    // synchronous-read memories; an armed fault flips bit 0 on every read
    always_ff @(posedge clk_i) begin
        for (int m = 0; m < MEM_CNT; m++) begin
            if (mem_we_o[m]) begin
                mem[m][mem_addr_o[m]] <= mem_wdata_o[m];
            end
            mem_rdata_i[m] <= mem[m][mem_addr_o[m]] ^ {15'h0000, fault[m]};
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one strobe, answer looked at one cycle later
    task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cpu_wr_i <= w;
        cpu_rd_i <= !w;
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        @(posedge clk_i);
        cpu_wr_i <= 1'b0;
        cpu_rd_i <= 1'b0;
        #1;
        chk("ack", 16'h0001, {15'h0000, cpu_ack_o});
        v = cpu_rdata_o;
    endtask

    task automatic rdchk(input string what, input logic [15:0] exp);
        acc(1'b0, RA, 16'h0000);
        chk(what, exp, v);
    endtask

    // polling: done flags only, bounded
    task automatic poll(input logic [15:0] mask);
        for (int i = 0; i < 100 && (v & mask) !== mask; i++) begin
            acc(1'b0, RA, 16'h0000);
        end
        chk("done", mask, v & mask);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdchk("reset", 16'h0000);
        acc(1'b0, 14'h0001, 16'h0000);
        chk("unmapped", 16'h0000, v);
        $display("test reset done");
        acc(1'b1, RA, 16'h1800);
        repeat (60) @(posedge clk_i);
        rdchk("arm_start", 16'h1800);
        acc(1'b1, RA, 16'h1000);
        $display("test arming done");
        v = 16'h0000;
        acc(1'b1, RA, 16'h1924);
        poll(16'h0492);
        rdchk("all_pass", 16'h1fff);
        chk("enable", 16'h0001, {15'h0000, self_test_enable_o});
        acc(1'b1, RA, 16'hf924);
        rdchk("ro_bits", 16'h1fff);
        $display("test all pass done");
        fault[1] = 1'b1;
        acc(1'b1, RA, 16'h1904);
        acc(1'b1, RA, 16'h1924);
        rdchk("restart", 16'h1fe7);
        poll(16'h0010);
        rdchk("fail", 16'h1ff7);
        $display("test fail done");
        acc(1'b1, RA, 16'h0000);
        repeat (3) @(posedge clk_i);
        rdchk("exit", 16'h0000);
        chk("disable", 16'h0000, {15'h0000, self_test_enable_o});
        $display("test exit done");
        final_report();
    end
endmodule // tb_top
